// >>> fp_control_status_pkg.sv
// Constants and types for the floating-point control and status register.
package fp_control_status_pkg;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int          EE_BIT   = 0;
    localparam int          ROUND_LSB = 1;
    localparam int          ROUND_MSB = 2;
    localparam int          FLAG_LSB = 3;
    localparam int          FLAG_MSB = 11;
    localparam int          FLAG_W   = FLAG_MSB - FLAG_LSB + 1;

    // ************************************************************
    // Flag order inside the status field
    // ************************************************************
    localparam int          OVERFLOW_IDX  = 0;
    localparam int          UNDERFLOW_IDX = 1;
    localparam int          SIG_NAN_IDX   = 2;
    localparam int          QUIET_NAN_IDX = 3;
    localparam int          ZERO_IDX      = 4;
    localparam int          INEXACT_IDX   = 5;
    localparam int          INVALID_IDX   = 6;
    localparam int          UNBOUNDED_IDX = 7;
    localparam int          DIV_ZERO_IDX  = 8;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic        RESET_EE    = 1'h0;
    localparam logic [1:0]  RESET_ROUND = 2'h0;
    localparam logic [8:0]  RESET_FLAGS = 9'h000;

    // Flags that raise an exception when enabled: overflow, underflow,
    // signaling NaN, invalid and divide by zero.
    localparam logic [8:0]  EXC_CAUSE_MASK = 9'h147;

    // ************************************************************
    // Rounding modes
    // ************************************************************
    typedef enum logic [1:0] {
        FP_CONTROL_STATUS_RND_NEAREST = 2'h0,
        FP_CONTROL_STATUS_RND_ZERO    = 2'h1,
        FP_CONTROL_STATUS_RND_POS_INF = 2'h2,
        FP_CONTROL_STATUS_RND_NEG_INF = 2'h3
    } fp_control_status_round_t;

endpackage

// >>> fp_control_status.sv
// Floating-point control and status register with flag collection.
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Behaviour
// RQ1: 32-bit register, readable and writable by software.
// RQ2: Completed instructions update the status flags.
// RQ3: Underflow uses tininess detected before rounding.
// RQ4: Writing zero flags clears all status flags; a flag raised by a completion in the same cycle is kept.
// RQ5: Handler clears flags before returning when enabled.
// RQ6: Bit 0 enables floating-point exceptions.
// RQ7: Bits 2-1 select the rounding mode.
// RQ8: Held rounding mode drives the datapath.
// RQ9: Exceptions raised only while enable bit set.
// RQ10: Flags sit in bits 3 to 11.
// RQ11: Flags stay readable after an exception.
// RQ12: Reserved bits read zero, writes ignored.
// RQ13: Reset clears every field to zero.
// ************************************************************

module fp_control_status #(
    parameter int XLEN = 32
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            spr_we,
    input  wire logic            spr_re,
    input  wire logic [XLEN-1:0] spr_wdata,
    output var  logic [XLEN-1:0] spr_rdata,
    input  wire logic            fpu_done,
    input  wire logic            fpu_overflow,
    input  wire logic            fpu_tiny,
    input  wire logic            fpu_snan,
    input  wire logic            fpu_qnan,
    input  wire logic            fpu_zero,
    input  wire logic            fpu_inexact,
    input  wire logic            fpu_invalid,
    input  wire logic            fpu_infinite,
    input  wire logic            fpu_div_zero,
    output var  logic            fp_exc_enable,
    output var  logic [1:0]      round_select,
    output var  logic            fp_exception
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // Wider cores keep the same low fields; the rest stays reserved.
    if (XLEN < 32) begin : g_bad_xlen
        $error("fp_control_status: XLEN must be at least 32");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic                 ee;
        fp_control_status_pkg::fp_control_status_round_t round;
        logic [8:0]           flags;
        logic [XLEN-1:0]      rdata;
        logic                 exc;
    } fp_control_status_state_t;

    fp_control_status_state_t q;
    fp_control_status_state_t next_q;

    logic [8:0] new_flags;
    logic       underflow;

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic [XLEN-1:0] pack_csr(
        input logic       ee,
        input logic [1:0] round,
        input logic [8:0] flags
    );
        logic [XLEN-1:0] v;
        v = '0; // see RQ12
        v[fp_control_status_pkg::EE_BIT] = ee;
        v[fp_control_status_pkg::ROUND_MSB:fp_control_status_pkg::ROUND_LSB] = round;
        v[fp_control_status_pkg::FLAG_MSB:fp_control_status_pkg::FLAG_LSB] = flags;
        return v;
    endfunction

    function automatic logic [8:0] wdata_flags(
        input logic [XLEN-1:0] w
    );
        return w[fp_control_status_pkg::FLAG_MSB:fp_control_status_pkg::FLAG_LSB];
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        // Tininess is judged on the unrounded result. With traps on, a
        // tiny result underflows even when exact, as the standard asks.
        underflow = fpu_tiny & (fpu_inexact | q.ee); // see RQ3
        new_flags = '0;
        new_flags[fp_control_status_pkg::OVERFLOW_IDX]  = fpu_overflow; // see RQ10
        new_flags[fp_control_status_pkg::UNDERFLOW_IDX] = underflow;
        new_flags[fp_control_status_pkg::SIG_NAN_IDX]   = fpu_snan;
        new_flags[fp_control_status_pkg::QUIET_NAN_IDX] = fpu_qnan;
        new_flags[fp_control_status_pkg::ZERO_IDX]      = fpu_zero;
        new_flags[fp_control_status_pkg::INEXACT_IDX]   = fpu_inexact;
        new_flags[fp_control_status_pkg::INVALID_IDX]   = fpu_invalid;
        new_flags[fp_control_status_pkg::UNBOUNDED_IDX] = fpu_infinite;
        new_flags[fp_control_status_pkg::DIV_ZERO_IDX]  = fpu_div_zero;
        if (!fpu_done) begin
            new_flags = '0;
        end

        next_q = q;
        if (spr_re) begin
            next_q.rdata = pack_csr(q.ee, q.round, q.flags); // see RQ1
        end
        if (spr_we) begin
            // Upper bits of the write word are simply not stored.
            next_q.ee = spr_wdata[fp_control_status_pkg::EE_BIT]; // see RQ6
            next_q.round = fp_control_status_pkg::fp_control_status_round_t'(
                spr_wdata[fp_control_status_pkg::ROUND_MSB:fp_control_status_pkg::ROUND_LSB]); // see RQ7
            // A flag raised in the clearing cycle survives the clear.
            next_q.flags = wdata_flags(spr_wdata) | new_flags; // see RQ4
        end else begin
            // Flags are sticky so the handler can still see the cause.
            next_q.flags = q.flags | new_flags; // see RQ2, RQ11
        end
        next_q.exc = q.ee & |(new_flags & fp_control_status_pkg::EXC_CAUSE_MASK); // see RQ9

        if (rst) begin
            next_q.ee    = fp_control_status_pkg::RESET_EE; // see RQ13
            next_q.round = fp_control_status_pkg::fp_control_status_round_t'(fp_control_status_pkg::RESET_ROUND);
            next_q.flags = fp_control_status_pkg::RESET_FLAGS;
            next_q.rdata = '0;
            next_q.exc   = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        q <= next_q;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign spr_rdata     = q.rdata;
    assign fp_exc_enable = q.ee;
    assign round_select  = q.round; // see RQ8
    assign fp_exception  = q.exc;

    // ************************************************************
    // Assertions
    // ************************************************************
    reserved_zero_a: assert property (@(posedge clk) disable iff (rst) // see RQ12
        spr_rdata[XLEN-1:fp_control_status_pkg::FLAG_MSB+1] == '0)
        else $error("reserved bits read nonzero");

    read_value_a: assert property (@(posedge clk) disable iff (rst) // see RQ1
        spr_re |=> spr_rdata == pack_csr($past(q.ee), $past(q.round), $past(q.flags)))
        else $error("read data does not match register");

    enable_write_a: assert property (@(posedge clk) disable iff (rst) // see RQ6
        spr_we |=> fp_exc_enable == $past(spr_wdata[fp_control_status_pkg::EE_BIT]))
        else $error("enable bit not written");

    round_write_a: assert property (@(posedge clk) disable iff (rst) // see RQ8
        spr_we |=> round_select == $past(spr_wdata[fp_control_status_pkg::ROUND_MSB:fp_control_status_pkg::ROUND_LSB]))
        else $error("rounding mode not written");

    flag_set_a: assert property (@(posedge clk) disable iff (rst) // see RQ2
        fpu_done && fpu_overflow |=> q.flags[fp_control_status_pkg::OVERFLOW_IDX] ##1
        (q.flags[fp_control_status_pkg::OVERFLOW_IDX] || $past(spr_we)))
        else $error("overflow flag not set");

    flag_clear_a: assert property (@(posedge clk) disable iff (rst) // see RQ4
        spr_we && wdata_flags(spr_wdata) == '0 && !fpu_done |=> q.flags == '0)
        else $error("flags not cleared by zero write");

    tiny_inexact_a: assert property (@(posedge clk) disable iff (rst) // see RQ3
        fpu_done && fpu_tiny && fpu_inexact |=> q.flags[fp_control_status_pkg::UNDERFLOW_IDX])
        else $error("tiny inexact result missed underflow");

    tiny_exact_a: assert property (@(posedge clk) disable iff (rst) // see RQ3
        fpu_done && fpu_tiny && !fpu_inexact && !q.ee && !spr_we &&
        !q.flags[fp_control_status_pkg::UNDERFLOW_IDX] |=> !q.flags[fp_control_status_pkg::UNDERFLOW_IDX])
        else $error("exact tiny result flagged underflow");

    exc_gate_a: assert property (@(posedge clk) disable iff (rst) // see RQ9
        !fp_exc_enable |=> !fp_exception)
        else $error("exception raised while disabled");

    exc_cause_a: assert property (@(posedge clk) disable iff (rst) // see RQ9
        fp_exc_enable && fpu_done && fpu_div_zero |=> fp_exception ##0
        q.flags[fp_control_status_pkg::DIV_ZERO_IDX])
        else $error("enabled divide by zero gave no exception");

    flags_hold_a: assert property (@(posedge clk) disable iff (rst) // see RQ11
        fp_exception |-> !spr_we && !fpu_done |=> $stable(q.flags))
        else $error("flags changed without cause");

    reset_clear_a: assert property (@(posedge clk) // see RQ13
        rst |=> pack_csr(q.ee, q.round, q.flags) == '0 && !fp_exception && spr_rdata == '0)
        else $error("reset did not clear register");

    // Each flag input gets its own check so a miswired index shows at once.
    snan_set_a: assert property (@(posedge clk) disable iff (rst) // see RQ2
        fpu_done && fpu_snan |=> q.flags[fp_control_status_pkg::SIG_NAN_IDX])
        else $error("signaling NaN flag not set");

    qnan_set_a: assert property (@(posedge clk) disable iff (rst) // see RQ2
        fpu_done && fpu_qnan |=> q.flags[fp_control_status_pkg::QUIET_NAN_IDX])
        else $error("quiet NaN flag not set");

    zero_set_a: assert property (@(posedge clk) disable iff (rst) // see RQ2
        fpu_done && fpu_zero |=> q.flags[fp_control_status_pkg::ZERO_IDX])
        else $error("zero result flag not set");

    inexact_set_a: assert property (@(posedge clk) disable iff (rst) // see RQ2
        fpu_done && fpu_inexact |=> q.flags[fp_control_status_pkg::INEXACT_IDX])
        else $error("inexact flag not set");

    invalid_set_a: assert property (@(posedge clk) disable iff (rst) // see RQ2
        fpu_done && fpu_invalid |=> q.flags[fp_control_status_pkg::INVALID_IDX])
        else $error("invalid flag not set");

    unbounded_set_a: assert property (@(posedge clk) disable iff (rst) // see RQ2
        fpu_done && fpu_infinite |=> q.flags[fp_control_status_pkg::UNBOUNDED_IDX])
        else $error("infinite result flag not set");

    div_zero_set_a: assert property (@(posedge clk) disable iff (rst) // see RQ2
        fpu_done && fpu_div_zero |=> q.flags[fp_control_status_pkg::DIV_ZERO_IDX])
        else $error("divide by zero flag not set");

    flags_sticky_a: assert property (@(posedge clk) disable iff (rst) // see RQ2
        !spr_we |=> (q.flags & $past(q.flags)) == $past(q.flags))
        else $error("flag dropped without a write");

    flags_idle_a: assert property (@(posedge clk) disable iff (rst) // see RQ2
        !spr_we && !fpu_done |=> $stable(q.flags))
        else $error("flags changed while idle");

    flags_write_a: assert property (@(posedge clk) disable iff (rst) // see RQ4
        spr_we && !fpu_done |=> q.flags == $past(wdata_flags(spr_wdata)))
        else $error("written flags not stored");

    flag_place_a: assert property (@(posedge clk) disable iff (rst) // see RQ10
        spr_re |=> spr_rdata[fp_control_status_pkg::FLAG_MSB:fp_control_status_pkg::FLAG_LSB] == $past(q.flags))
        else $error("flags read from wrong bits");

    underflow_trap_a: assert property (@(posedge clk) disable iff (rst) // see RQ3
        fpu_done && fpu_tiny && q.ee |=> q.flags[fp_control_status_pkg::UNDERFLOW_IDX])
        else $error("trapped tiny result missed underflow");

    tiny_absent_a: assert property (@(posedge clk) disable iff (rst) // see RQ3
        fpu_done && !fpu_tiny && !spr_we &&
        !q.flags[fp_control_status_pkg::UNDERFLOW_IDX] |=> !q.flags[fp_control_status_pkg::UNDERFLOW_IDX])
        else $error("underflow without tiny result");

    enable_hold_a: assert property (@(posedge clk) disable iff (rst) // see RQ6
        !spr_we |=> $stable(fp_exc_enable))
        else $error("enable bit changed without write");

    round_hold_a: assert property (@(posedge clk) disable iff (rst) // see RQ8
        !spr_we |=> $stable(round_select))
        else $error("rounding mode changed without write");

    // Read data is held between reads so a stalled move still sees its word.
    rdata_hold_a: assert property (@(posedge clk) disable iff (rst) // see RQ1
        !spr_re |=> $stable(spr_rdata))
        else $error("read data changed without read");

    exc_idle_a: assert property (@(posedge clk) disable iff (rst) // see RQ9
        !fpu_done |=> !fp_exception)
        else $error("exception without completion");

    exc_overflow_a: assert property (@(posedge clk) disable iff (rst) // see RQ9
        fp_exc_enable && fpu_done && fpu_overflow |=> fp_exception)
        else $error("enabled overflow gave no exception");

    exc_tiny_a: assert property (@(posedge clk) disable iff (rst) // see RQ9
        fp_exc_enable && fpu_done && fpu_tiny |=> fp_exception)
        else $error("enabled underflow gave no exception");

    exc_snan_a: assert property (@(posedge clk) disable iff (rst) // see RQ9
        fp_exc_enable && fpu_done && fpu_snan |=> fp_exception)
        else $error("enabled signaling NaN gave no exception");

    exc_invalid_a: assert property (@(posedge clk) disable iff (rst) // see RQ9
        fp_exc_enable && fpu_done && fpu_invalid |=> fp_exception)
        else $error("enabled invalid gave no exception");

    exc_quiet_a: assert property (@(posedge clk) disable iff (rst) // see RQ9
        fpu_done && !fpu_overflow && !fpu_tiny && !fpu_snan && !fpu_invalid && !fpu_div_zero |=> !fp_exception)
        else $error("exception from a non-causing result");

endmodule

`default_nettype wire

// >>> fp_control_status_bench.sv
// Self-checking bench for the floating-point control and status register.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp); end end

module fp_control_status_bench;
    logic        clk;
    logic        rst;
    logic        spr_we;
    logic        spr_re;
    logic [31:0] spr_wdata;
    logic [31:0] spr_rdata;
    logic        fpu_done;
    logic [8:0]  fin;
    logic        fp_exc_enable;
    logic [1:0]  round_select;
    logic        fp_exception;
    int          err_total;
    int          cmp_count;
    integer      seed;
    logic        m_ee;
    logic [1:0]  m_round;
    logic [8:0]  m_fl;

    fp_control_status i_fp_control_status (.clk(clk), .rst(rst), .spr_we(spr_we), .spr_re(spr_re), .spr_wdata(spr_wdata),
        .spr_rdata(spr_rdata), .fpu_done(fpu_done), .fpu_overflow(fin[0]), .fpu_tiny(fin[1]),
        .fpu_snan(fin[2]), .fpu_qnan(fin[3]), .fpu_zero(fin[4]), .fpu_inexact(fin[5]),
        .fpu_invalid(fin[6]), .fpu_infinite(fin[7]), .fpu_div_zero(fin[8]),
        .fp_exc_enable(fp_exc_enable), .round_select(round_select), .fp_exception(fp_exception));

    // ************************************************************
    // Expectation helpers
    // ************************************************************
    function automatic logic [31:0] word_of(logic ee, logic [1:0] round, logic [8:0] fl);
        return {20'h00000, fl, round, ee};
    endfunction

    // Underflow counts only when tiny before rounding and inexact or trapping.
    function automatic logic [8:0] eff_flags(logic [8:0] f, logic ee);
        logic [8:0] r;
        r = f;
        r[fp_control_status_pkg::UNDERFLOW_IDX] = f[fp_control_status_pkg::UNDERFLOW_IDX] & (f[fp_control_status_pkg::INEXACT_IDX] | ee);
        return r;
    endfunction

    task automatic wr(input logic [31:0] d);
        @(posedge clk);
        spr_we    <= 1'h1;
        spr_wdata <= d;
        @(posedge clk);
        spr_we    <= 1'h0;
        m_ee = d[0];
        m_round = d[2:1];
        m_fl = d[11:3];
        @(negedge clk);
        `CHK(fp_exc_enable, m_ee)
        `CHK(round_select, m_round)
    endtask

    task automatic rd();
        @(posedge clk);
        spr_re <= 1'h1;
        @(posedge clk);
        spr_re <= 1'h0;
        @(negedge clk);
        `CHK(spr_rdata, word_of(m_ee, m_round, m_fl))
    endtask

    // Flag lines are inverted once the completion ends, so ignored inputs still toggle.
    task automatic fp(input logic [8:0] f);
        logic [8:0] nf;
        nf = eff_flags(f, m_ee);
        @(posedge clk);
        fpu_done <= 1'h1;
        fin      <= f;
        @(posedge clk);
        fpu_done <= 1'h0;
        fin      <= ~f;
        m_fl = m_fl | nf;
        @(negedge clk);
        `CHK(fp_exception, m_ee & (|(nf & fp_control_status_pkg::EXC_CAUSE_MASK)))
        @(negedge clk);
        `CHK(fp_exception, 1'h0)
        rd();
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ************************************************************
    // Clock, watchdog and sequence
    // ************************************************************
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    initial begin
        #200000;
        err_total++;
        results();
    end

    initial begin
        logic [31:0] d;
        seed = 79635;
        err_total = 0;
        cmp_count = 0;
        {rst, spr_we, spr_re, fpu_done, m_ee, m_round, m_fl} = '0;
        rst = 1'h1;
        spr_wdata = 32'h00000000;
        fin = 9'h000;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rd();
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            d[2:0] = i[2:0];
            wr(d);
            rd();
        end
        $display("test control fields done");
        for (int e = 0; e < 2; e++) begin
            wr({31'h00000000, e[0]});
            for (int b = 0; b < 9; b++) begin
                fp(9'h001 << b);
            end
            fp(9'h022);
        end
        $display("test single flags done");
        for (int i = 0; i < 30; i++) begin
            if (i % 7 == 0) begin
                wr($random(seed));
            end
            d = $random(seed);
            fp(d[8:0]);
        end
        $display("test random traffic done");
        // The handler's duty: clear flags before returning with traps on.
        wr(32'hfffff007);
        rd();
        $display("test flag clear done");
        @(posedge clk);
        rst <= 1'h1;
        @(posedge clk);
        rst <= 1'h0;
        {m_ee, m_round, m_fl} = '0;
        @(negedge clk);
        `CHK({fp_exc_enable, round_select}, 3'h0)
        rd();
        $display("test second reset done");
        results();
    end
endmodule
`default_nettype wire
